// ===== hdl/lsa_status_bank.sv
`timescale 1ns/1ps
module lsa_status_bank
	import lsa_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        io_wr,
	input  wire logic        io_rd,
	input  wire logic [7:0]  io_addr,
	input  wire logic [15:0] io_wdata,
	output logic      [15:0] io_rdata,
	input  wire logic [15:0] general_purpose_input,
	input  wire logic [15:0] input_active,
	input  wire logic [15:0] input_route_select,
	input  wire logic [15:0] input_implemented,
	input  wire logic [3:0]  monitor_hit,
	input  wire logic        keyboard_hit,
	input  wire logic        legacy_hit,
	input  wire logic [3:0]  drive_hit,
	input  wire logic [7:0]  pci_irq_active,
	output logic             system_mgmt_interrupt_n,
	output logic             general_event_summary,
	output logic [15:0]      device_activity_status,
	output logic [15:0]      forward_block
);
	logic [15:0] alt_en;
	logic [15:0] alt_sts;
	logic [15:0] mon_sts;
	logic [15:0] mon_en;
	logic [15:0] devact;
	logic [15:0] trap_en;
	logic        rst_seen_q;
	logic        smi_n_q;
	logic        summary_q;
	logic [15:0] act_q;
	logic [15:0] blk_q;
	logic [15:0] rdata_q;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	wire         wr_en      = io_wr && hit(io_addr, LSA_OFS_ENABLE);
	wire         wr_alt     = io_wr && hit(io_addr, LSA_OFS_ALT_STS);
	wire         wr_mon     = io_wr && hit(io_addr, LSA_OFS_MON);
	wire         wr_dev     = io_wr && hit(io_addr, LSA_OFS_DEVACT);
	wire         wr_trap    = io_wr && hit(io_addr, LSA_OFS_TRAP_EN);
	wire [15:0]  alt_clr    = wr_alt ? io_wdata : LSA_ZERO16;
	wire [15:0]  dev_clr    = wr_dev ? io_wdata : LSA_ZERO16;
	wire [15:0]  mon_clr    = wr_mon ? io_wdata : LSA_ZERO16;
	wire [15:0]  alt_set    = input_active & input_implemented;
	wire [3:0]   mon_en4    = mon_en[LSA_MON_EN_LO +: 4];
	wire [15:0]  mon_set    = {monitor_hit & mon_en4, 12'h000};
	wire [3:0]   irq_pair   = pci_irq_active[3:0] | pci_irq_active[7:4];
	wire [15:0]  dev_set;
	wire [15:0]  smi_src    = alt_sts & alt_en & input_route_select
	                          & input_implemented;
	wire         summary_d  = |smi_src;
	wire         trap_any   = |(devact & trap_en) || |mon_sts[15:12];
	wire [15:0]  rd_mux;

	assign dev_set = ({15'h0000, keyboard_hit} << LSA_BIT_KBC)
	               | ({12'h000, irq_pair} << LSA_BIT_IRQ_LO)
	               | ({15'h0000, legacy_hit} << LSA_BIT_LEGACY)
	               | ({12'h000, drive_hit} << LSA_BIT_DRIVE_LO);

	assign rd_mux = hit(io_addr, LSA_OFS_ENABLE)  ? alt_en  :
	                hit(io_addr, LSA_OFS_ALT_STS) ? alt_sts :
	                hit(io_addr, LSA_OFS_MON)     ? (mon_sts | mon_en) :
	                hit(io_addr, LSA_OFS_DEVACT)  ? devact  :
	                hit(io_addr, LSA_OFS_TRAP_EN) ? trap_en : LSA_ZERO16;

	lsa_rw_reg u_alt_en (
		.ref_clk    (ref_clk),
		.rst_n      (rst_n),
		.wr         (wr_en),
		.wdata      (io_wdata),
		.valid_mask (16'hffff),
		.value      (alt_en)
	);

	// status is seeded from pin levels on the first clock after reset
	lsa_w1c_reg u_alt_sts (
		.ref_clk    (ref_clk),
		.rst_n      (rst_n),
		.set_bits   (alt_set),
		.clr_bits   (alt_clr),
		.valid_mask (16'hffff),
		.load       (!rst_seen_q),
		.load_val   (general_purpose_input & input_implemented),
		.value      (alt_sts)
	);

	lsa_w1c_reg u_mon_sts (
		.ref_clk    (ref_clk),
		.rst_n      (rst_n),
		.set_bits   (mon_set),
		.clr_bits   (mon_clr),
		.valid_mask (16'hf000),
		.load       (1'b0),
		.load_val   (LSA_ZERO16),
		.value      (mon_sts)
	);

	lsa_rw_reg u_mon_en (
		.ref_clk    (ref_clk),
		.rst_n      (rst_n),
		.wr         (wr_mon),
		.wdata      (io_wdata),
		.valid_mask (16'h0f00),
		.value      (mon_en)
	);

	lsa_w1c_reg u_devact (
		.ref_clk    (ref_clk),
		.rst_n      (rst_n),
		.set_bits   (dev_set),
		.clr_bits   (dev_clr),
		.valid_mask (LSA_DEVACT_MASK),
		.load       (1'b0),
		.load_val   (LSA_ZERO16),
		.value      (devact)
	);

	lsa_rw_reg u_trap_en (
		.ref_clk    (ref_clk),
		.rst_n      (rst_n),
		.wr         (wr_trap),
		.wdata      (io_wdata),
		.valid_mask (LSA_TRAP_EN_MASK),
		.value      (trap_en)
	);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_seen_q <= 1'b0;
			smi_n_q    <= 1'b1;
			summary_q  <= 1'b0;
			act_q      <= LSA_ZERO16;
			blk_q      <= LSA_ZERO16;
			rdata_q    <= LSA_ZERO16;
		end else begin
			rst_seen_q <= 1'b1;
			smi_n_q    <= !(summary_d || trap_any);
			summary_q  <= summary_d;
			act_q      <= devact;
			blk_q      <= trap_en;
			rdata_q    <= io_rd ? rd_mux : LSA_ZERO16;
		end
	end

	assign system_mgmt_interrupt_n = smi_n_q;
	assign general_event_summary   = summary_q;
	assign device_activity_status  = act_q;
	assign forward_block           = blk_q;
	assign io_rdata                = rdata_q;

	// assertions
	summary_or_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		general_event_summary == $past(summary_d))
		else $error("summary bit does not match enabled routed status");

	smi_cause_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$past(rst_seen_q) && !system_mgmt_interrupt_n |-> $past(summary_d || trap_any))
		else $error("interrupt raised without a cause");

	alt_sticky_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rst_seen_q && alt_sts[0] && !(wr_alt && io_wdata[0]) |=> alt_sts[0])
		else $error("input status bit lost without a clear");

	alt_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rst_seen_q && wr_alt && io_wdata[0] && !alt_set[0] |=> !alt_sts[0])
		else $error("input status write one did not clear");

	kbc_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		keyboard_hit |=> devact[LSA_BIT_KBC] ##1 device_activity_status[LSA_BIT_KBC])
		else $error("keyboard access not recorded");

	set_wins_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		drive_hit[2] && wr_dev && io_wdata[2] |=> devact[2])
		else $error("set lost against clear");

	reserved_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(devact & ~LSA_DEVACT_MASK) == LSA_ZERO16 && mon_en[7:0] == 8'h00)
		else $error("reserved bit set");

	irq_pair_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		pci_irq_active[7] |=> devact[LSA_BIT_IRQ_LO + 3])
		else $error("irq pair activity not recorded");

	mon_trap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		monitor_hit[0] && mon_en[LSA_MON_EN_LO] |=> mon_sts[LSA_MON_STS_LO])
		else $error("monitor trap flag not set");
endmodule : lsa_status_bank

// ===== hdl/lsa_pkg.sv
package lsa_pkg;
	// register offsets from the power management I/O base
	localparam logic [7:0]  LSA_OFS_ENABLE   = 8'h38;
	localparam logic [7:0]  LSA_OFS_ALT_STS  = 8'h3a;
	localparam logic [7:0]  LSA_OFS_MON      = 8'h40;
	localparam logic [7:0]  LSA_OFS_DEVACT   = 8'h44;
	localparam logic [7:0]  LSA_OFS_TRAP_EN  = 8'h48;
	// device activity layout
	localparam int          LSA_BIT_KBC      = 12;
	localparam int          LSA_BIT_IRQ_LO   = 6;
	localparam int          LSA_BIT_LEGACY   = 5;
	localparam int          LSA_BIT_DRIVE_LO = 0;
	localparam logic [15:0] LSA_DEVACT_MASK  = 16'h13ef;
	localparam logic [15:0] LSA_TRAP_EN_MASK = 16'h102f;
	// monitor register layout
	localparam int          LSA_MON_STS_LO   = 12;
	localparam int          LSA_MON_EN_LO    = 8;
	localparam logic [15:0] LSA_ZERO16       = 16'h0000;
endpackage : lsa_pkg

// ===== hdl/lsa_w1c_reg.sv
`timescale 1ns/1ps
// sticky status word: set wins over write-one clear
module lsa_w1c_reg (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic [15:0] set_bits,
	input  wire logic [15:0] clr_bits,
	input  wire logic [15:0] valid_mask,
	input  wire logic        load,
	input  wire logic [15:0] load_val,
	output logic      [15:0] value
);
	import lsa_pkg::*;
	logic [15:0] sts_q;
	logic [15:0] sts_d;

	assign sts_d = load ? (load_val & valid_mask)
	                    : (((sts_q & ~clr_bits) | set_bits) & valid_mask);
	assign value = sts_q;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sts_q <= LSA_ZERO16;
		end else begin
			sts_q <= sts_d;
		end
	end
endmodule : lsa_w1c_reg

// ===== hdl/lsa_rw_reg.sv
`timescale 1ns/1ps
// plain read-write word with writable-bit mask
module lsa_rw_reg (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        wr,
	input  wire logic [15:0] wdata,
	input  wire logic [15:0] valid_mask,
	output logic      [15:0] value
);
	import lsa_pkg::*;
	logic [15:0] val_q;

	assign value = val_q;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			val_q <= LSA_ZERO16;
		end else if (wr) begin
			val_q <= wdata & valid_mask;
		end
	end
endmodule : lsa_rw_reg

// ===== testbench/lsa_host_model.sv
`timescale 1ns/1ps
// host side: single-cycle I/O strobes, driven at the falling edge
module lsa_host_model (
	input  wire logic        ref_clk,
	output logic             io_wr,
	output logic             io_rd,
	output logic [7:0]       io_addr,
	output logic [15:0]      io_wdata,
	input  wire logic [15:0] io_rdata
);
	initial begin
		io_wr    = 1'b0;
		io_rd    = 1'b0;
		io_addr  = 8'h00;
		io_wdata = 16'h0000;
	end
	task automatic io_write(input logic [7:0] a, input logic [15:0] d);
		@(negedge ref_clk);
		io_addr  = a;
		io_wdata = d;
		io_wr    = 1'b1;
		@(negedge ref_clk);
		io_wr    = 1'b0;
		io_addr  = ~a;
		io_wdata = ~d;
	endtask : io_write
	task automatic io_read(input logic [7:0] a, output logic [15:0] d);
		@(negedge ref_clk);
		io_addr = a;
		io_rd   = 1'b1;
		@(negedge ref_clk);
		io_rd   = 1'b0;
		io_addr = ~a;
		d       = io_rdata;
	endtask : io_read
endmodule : lsa_host_model

// ===== testbench/tb_legacy_smi_activity_status.sv
`timescale 1ns/1ps
module tb_legacy_smi_activity_status;
	import lsa_pkg::*;
	logic        ref_clk, rst_n, io_wr, io_rd, keyboard_hit, legacy_hit;
	logic        system_mgmt_interrupt_n, general_event_summary;
	logic [7:0]  io_addr, pci_irq_active;
	logic [3:0]  monitor_hit, drive_hit;
	logic [15:0] io_wdata, io_rdata, general_purpose_input, input_active, input_route_select;
	logic [15:0] input_implemented, device_activity_status, forward_block, r, e, m, v;
	int          n_fail, n_tests;
	lsa_status_bank dut_u (.ref_clk, .rst_n, .io_wr, .io_rd, .io_addr, .io_wdata, .io_rdata,
		.general_purpose_input, .input_active, .input_route_select, .input_implemented,
		.monitor_hit, .keyboard_hit, .legacy_hit, .drive_hit, .pci_irq_active,
		.system_mgmt_interrupt_n, .general_event_summary, .device_activity_status,
		.forward_block);
	lsa_host_model host_u (.ref_clk, .io_wr, .io_rd, .io_addr, .io_wdata, .io_rdata);
	function automatic logic [15:0] exp_act(input logic [15:0] s);
		logic [15:0] x;
		x = LSA_ZERO16;
		x[LSA_BIT_KBC] = s[0];
		x[LSA_BIT_LEGACY] = s[1];
		x[3:0] = s[5:2];
		x[9:6] = s[9:6] | s[13:10];
		return x;
	endfunction : exp_act
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		host_u.io_read(a, v);
		chk(v, exp);
	endtask : rd
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : wrap_up
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	initial begin
		#100us;
		n_fail++;
		wrap_up();
	end
	initial begin
		void'($urandom(98));
		{rst_n, keyboard_hit, legacy_hit, drive_hit, monitor_hit, pci_irq_active} = '0;
		{input_active, input_route_select} = '0;
		general_purpose_input = 16'($urandom);
		input_implemented = 16'($urandom);
		repeat (4) @(negedge ref_clk);
		rst_n = 1'b1;
		@(negedge ref_clk);
		rd(LSA_OFS_ALT_STS, general_purpose_input & input_implemented);
		rd(LSA_OFS_DEVACT, LSA_ZERO16);
		input_implemented = 16'hffff;
		for (int k = 0; k < 8; k++) begin
			r = (k == 0) ? 16'hffff : 16'($urandom);
			m = 16'($urandom);
			@(negedge ref_clk);
			{pci_irq_active, drive_hit, legacy_hit, keyboard_hit} = r[13:0];
			@(negedge ref_clk);
			{pci_irq_active, drive_hit, legacy_hit, keyboard_hit} = 14'h0;
			e = exp_act(r);
			rd(LSA_OFS_DEVACT, e);
			chk(device_activity_status, e);
			host_u.io_write(LSA_OFS_DEVACT, m);
			rd(LSA_OFS_DEVACT, e & ~m);
			host_u.io_write(LSA_OFS_DEVACT, 16'hffff);
		end
		fork
			host_u.io_write(LSA_OFS_DEVACT, 16'hffff);
			begin
				@(negedge ref_clk);
				keyboard_hit = 1'b1;
				drive_hit    = 4'h4;
				@(negedge ref_clk);
				keyboard_hit = 1'b0;
				drive_hit    = 4'h0;
			end
		join
		rd(LSA_OFS_DEVACT, 16'h1004);
		host_u.io_write(LSA_OFS_DEVACT, 16'hffff);
		r = 16'($urandom);
		host_u.io_write(LSA_OFS_TRAP_EN, r);
		rd(LSA_OFS_TRAP_EN, r & LSA_TRAP_EN_MASK);
		chk(forward_block, r & LSA_TRAP_EN_MASK);
		rd(8'h50, LSA_ZERO16);
		host_u.io_write(LSA_OFS_TRAP_EN, LSA_ZERO16);
		for (int k = 0; k < 4; k++) begin
			r = (k == 0) ? 16'hffff : 16'($urandom);
			host_u.io_write(LSA_OFS_MON, r);
			@(negedge ref_clk);
			monitor_hit = r[15:12];
			@(negedge ref_clk);
			monitor_hit = 4'h0;
			rd(LSA_OFS_MON, {r[15:12] & r[11:8], r[11:8], 8'h00});
			host_u.io_write(LSA_OFS_MON, 16'hf000);
		end
		host_u.io_write(LSA_OFS_ALT_STS, 16'hffff);
		for (int k = 0; k < 6; k++) begin
			e = (k == 0) ? 16'hffff : 16'($urandom);
			r = 16'($urandom);
			m = 16'($urandom);
			host_u.io_write(LSA_OFS_ENABLE, e);
			input_route_select = (k == 0) ? 16'h0000 : 16'($urandom);
			@(negedge ref_clk);
			input_active = r;
			@(negedge ref_clk);
			input_active = 16'h0000;
			rd(LSA_OFS_ALT_STS, r);
			chk({15'h0, general_event_summary}, {15'h0, |(r & e & input_route_select)});
			chk({15'h0, system_mgmt_interrupt_n}, {15'h0, ~|(r & e & input_route_select)});
			host_u.io_write(LSA_OFS_ALT_STS, m);
			rd(LSA_OFS_ALT_STS, r & ~m);
			host_u.io_write(LSA_OFS_ALT_STS, 16'hffff);
		end
		wrap_up();
	end
endmodule : tb_legacy_smi_activity_status
